// ==== inc/phy_eee_regs.svh ====
// register offsets, field positions, reset values and timing counts
`ifndef PHY_EEE_REGS_SVH
`define PHY_EEE_REGS_SVH

// register byte offsets on the apb bus
`define OFS_PHY_CONTROL_ONE   8'h00
`define OFS_EEE_ADVERT        8'h04
`define OFS_EEE_PARTNER       8'h08
`define OFS_MEDIA_IF_STATUS   8'h0C
`define OFS_IRQ_MASK          8'h10
`define OFS_WAKE_CTRL         8'h14
`define OFS_WAKE_STATUS       8'h18
`define OFS_WAKE_ADDR0        8'h20
`define OFS_WAKE_PASS0        8'h38
`define OFS_WAKE_STEP         8'h04

// field positions
`define BIT_AMP_ENABLE        0
`define BIT_ADV_100           1
`define BIT_ADV_1000          2
`define BIT_STAT_EEE          0
`define BIT_STAT_FALLBACK     1
`define BIT_STAT_TX_LPI       2
`define BIT_STAT_RX_LPI       3
`define BIT_WAKE_IRQ_MASK     0
`define BIT_WAKE_ENABLE       0
`define BIT_WAKE_EVENT        0

// reset values
`define RST_PHY_CONTROL_ONE   1'b0
`define RST_EEE_ADVERT        3'h0
`define RST_WAKE_BYTE         8'h00

// lpi code on txd/rxd and magic packet figures
`define LPI_CODE              8'h01
`define LPI_CODE_NIBBLE       4'h1
`define SYNC_BYTE             8'hFF
`define SYNC_LEN              3'd6
`define ADDR_LEN              3'd6
`define ADDR_COPIES           5'd16
`define PASS_LEN              3'd6

// wake times, clock period and derived cycle counts (round down)
`define CLK_PERIOD_NS         100
`define WAKE_100_NS           20500
`define WAKE_1000_NS          30000
`define WAKE_100_CYC          (`WAKE_100_NS / `CLK_PERIOD_NS)
`define WAKE_1000_CYC         (`WAKE_1000_NS / `CLK_PERIOD_NS)

`endif

// ==== inc/phy_eee_pkg.sv ====
// types shared by the eee / wake block
package phy_eee_pkg;

  // resolved line speed
  typedef enum logic [1:0] {SPD_10, SPD_100, SPD_1000} speed_e;

  // transmit low power sequencing
  typedef enum logic [1:0] {TX_ACTIVE, TX_SLEEP, TX_QUIET, TX_WAKE} tx_state_e;

  // magic packet search phase
  typedef enum logic [1:0] {MP_SYNC, MP_ADDR, MP_PASS} mp_state_e;

  // mac side transmit group
  typedef struct packed {
    logic       en;
    logic       er;
    logic [7:0] d;
  } mii_tx_s;

  // mac side receive group
  typedef struct packed {
    logic       dv;
    logic       er;
    logic [7:0] d;
  } mii_rx_s;

  // whole state of the block
  typedef struct packed {
    logic            amp_en;
    logic [2:0]      adv;
    logic [2:0]      lp_adv;
    logic            eee_cap;
    logic            amp_fallback;
    logic            irq_mask;
    logic            wake_en;
    logic            wake_evt;
    logic [5:0][7:0] waddr;
    logic [5:0][7:0] wpass;
    logic [31:0]     rdata;
    logic            slverr;
    logic            aneg_q;
    tx_state_e       tx_st;
    logic [8:0]      tx_cnt;
    logic            rx_lpi;
    logic            rx_wake;
    logic [8:0]      rx_cnt;
    mii_rx_s         rx_out;
    mp_state_e       mp_st;
    logic [2:0]      sync_cnt;
    logic [2:0]      mp_pos;
    logic [3:0]      mp_copy;
    logic            m_addr;
    logic            m_bcast;
    logic            detect;
  } phy_state_s;

endpackage

// ==== hdl/phy_eee_lpi_wol.sv ====
// eee low power idle, eee resolution and magic packet wake detector
//
// Chosen here: register access over APB and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "phy_eee_regs.svh"

module phy_eee_lpi_wol
  import phy_eee_pkg::*;
#(
  parameter int ADDR_W = 8                   // apb address width
)
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire mii_tx_s           mac_tx,
  output mii_rx_s                mac_rx,
  input  wire mii_rx_s           line_rx,
  input  wire logic              line_rx_frame,
  input  wire logic              partner_lpi,
  input  wire logic              marginal_link,
  input  wire logic              link_up,
  input  wire speed_e            link_speed,
  input  wire logic              aneg_done,
  input  wire logic [2:0]        partner_ability,
  output logic                   amp_reduced,
  output logic                   tx_lpi_signal,
  output logic                   tx_quiet,
  output logic                   rx_path_off,
  output logic [2:0]             eee_np_ability,
  output logic                   eee_np_valid,
  output logic                   eee_capable,
  output logic                   mgmt_interrupt_out
);

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------

  // lpi code on the transmit group at the given speed
  function automatic logic is_lpi(input mii_tx_s t, input speed_e sp);
    logic code_ok;
    code_ok = (sp == SPD_1000) ? (t.d == `LPI_CODE)
                               : (t.d[3:0] == `LPI_CODE_NIBBLE);
    return !t.en && t.er && code_ok;
  endfunction

  phy_state_s s;                             // registered state
  phy_state_s n;                             // next state
  logic [7:0] off;                           // low address byte
  logic       wr_acc;                        // write access phase
  logic       rd_setup;                      // read setup phase
  logic       tx_req;                        // mac lpi request
  logic       pass_set;                      // password defined
  logic       byte_ok;                       // address byte hit
  logic       addr_hit;                      // per byte own match
  logic       bc_hit;                        // per byte broadcast

  assign off      = paddr[7:0];
  assign wr_acc   = psel && penable && pwrite;
  assign rd_setup = psel && !penable;
  assign tx_req   = is_lpi(mac_tx, link_speed);
  // all zero password means none is defined
  assign pass_set = (s.wpass != '0);

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------

  // one process computes every next value
  always_comb
  begin
    n         = s;
    addr_hit  = 1'b0;
    bc_hit    = 1'b0;
    byte_ok   = 1'b0;
    n.detect  = 1'b0;
    n.aneg_q  = aneg_done;

    // apb write, taken in the access phase only
    if (wr_acc)
    begin
      unique case (off)
        `OFS_PHY_CONTROL_ONE: n.amp_en = pwdata[`BIT_AMP_ENABLE];
        `OFS_EEE_ADVERT:      n.adv    = pwdata[2:0];
        `OFS_IRQ_MASK:        n.irq_mask = pwdata[`BIT_WAKE_IRQ_MASK];
        `OFS_WAKE_CTRL:       n.wake_en  = pwdata[`BIT_WAKE_ENABLE];
        `OFS_WAKE_STATUS:
          // write one clears; a new detect below still wins
          if (pwdata[`BIT_WAKE_EVENT])
            n.wake_evt = 1'b0;
        default:
          for (int i = 0; i < 6; i++)
          begin
            if (off == `OFS_WAKE_ADDR0 + 8'(i * 4))
              n.waddr[i] = pwdata[7:0];
            if (off == `OFS_WAKE_PASS0 + 8'(i * 4))
              n.wpass[i] = pwdata[7:0];
          end
      endcase
    end

    // read data captured in setup, shown in the access phase
    if (rd_setup)
    begin
      n.rdata  = '0;
      n.slverr = 1'b0;
      unique case (off)
        `OFS_PHY_CONTROL_ONE: n.rdata[`BIT_AMP_ENABLE] = s.amp_en;
        `OFS_EEE_ADVERT:      n.rdata[2:0] = s.adv;
        `OFS_EEE_PARTNER:     n.rdata[2:0] = s.lp_adv;
        `OFS_MEDIA_IF_STATUS:
        begin
          n.rdata[`BIT_STAT_EEE]      = s.eee_cap;
          n.rdata[`BIT_STAT_FALLBACK] = s.amp_fallback;
          n.rdata[`BIT_STAT_TX_LPI]   = (s.tx_st != TX_ACTIVE);
          n.rdata[`BIT_STAT_RX_LPI]   = s.rx_lpi;
        end
        `OFS_IRQ_MASK:    n.rdata[`BIT_WAKE_IRQ_MASK] = s.irq_mask;
        `OFS_WAKE_CTRL:   n.rdata[`BIT_WAKE_ENABLE]   = s.wake_en;
        `OFS_WAKE_STATUS: n.rdata[`BIT_WAKE_EVENT]    = s.wake_evt;
        default:
        begin
          // unmapped offsets answer with an error
          n.slverr = 1'b1;
          for (int i = 0; i < 6; i++)
          begin
            if (off == `OFS_WAKE_ADDR0 + 8'(i * 4))
            begin
              n.rdata[7:0] = s.waddr[i];
              n.slverr     = 1'b0;
            end
            if (off == `OFS_WAKE_PASS0 + 8'(i * 4))
            begin
              n.rdata[7:0] = s.wpass[i];
              n.slverr     = 1'b0;
            end
          end
        end
      endcase
    end

    // 10m amplitude fallback, sticky until link or enable drops
    if (!link_up || !s.amp_en)
      n.amp_fallback = 1'b0;
    else if (marginal_link && link_speed == SPD_10)
      n.amp_fallback = 1'b1;

    // partner abilities latched on negotiation completion
    if (aneg_done && !s.aneg_q)
      n.lp_adv = partner_ability;

    // resolution with speed; zero advertisement kills eee
    n.eee_cap = link_up && (
      (link_speed == SPD_100  && s.adv[`BIT_ADV_100]  &&
       s.lp_adv[`BIT_ADV_100]) ||
      (link_speed == SPD_1000 && s.adv[`BIT_ADV_1000] &&
       s.lp_adv[`BIT_ADV_1000]));

    // transmit direction, independent of receive at the mac
    unique case (s.tx_st)
      TX_ACTIVE:
        if (s.eee_cap && tx_req)
          // 100m goes low power at once, gigabit sends sleep first
          n.tx_st = (link_speed == SPD_1000) ? TX_SLEEP
                                             : TX_QUIET;
      TX_SLEEP:
        if (!tx_req || !s.eee_cap)
        begin
          n.tx_st  = TX_WAKE;
          n.tx_cnt = 9'(`WAKE_1000_CYC - 1);
        end
        else if (partner_lpi)
          n.tx_st = TX_QUIET;
      TX_QUIET:
        if (!tx_req || !s.eee_cap)
        begin
          n.tx_st  = TX_WAKE;
          n.tx_cnt = (link_speed == SPD_1000)
                     ? 9'(`WAKE_1000_CYC - 1)
                     : 9'(`WAKE_100_CYC - 1);
        end
      TX_WAKE:
        if (s.tx_cnt == '0)
          n.tx_st = TX_ACTIVE;
        else
          n.tx_cnt = s.tx_cnt - 9'd1;
    endcase

    // receive direction: lpi sensed from the line
    if (s.eee_cap && partner_lpi)
    begin
      n.rx_lpi  = 1'b1;
      n.rx_wake = 1'b0;
    end
    else if (s.rx_lpi)
    begin
      n.rx_lpi  = 1'b0;
      n.rx_wake = 1'b1;
      n.rx_cnt  = (link_speed == SPD_1000)
                  ? 9'(`WAKE_1000_CYC - 1)
                  : 9'(`WAKE_100_CYC - 1);
    end
    else if (s.rx_wake)
    begin
      if (s.rx_cnt == '0)
        n.rx_wake = 1'b0;
      else
        n.rx_cnt = s.rx_cnt - 9'd1;
    end

    // receive group towards the mac
    if (n.rx_lpi)
      n.rx_out = '{dv: 1'b0, er: 1'b1, d: `LPI_CODE};
    else if (n.rx_wake)
      n.rx_out = '0;                         // idle while path wakes
    else
      n.rx_out = line_rx;

    // magic packet search, speed independent byte stream
    if (!line_rx_frame || !s.wake_en)
    begin
      n.mp_st    = MP_SYNC;
      n.sync_cnt = '0;
    end
    else if (line_rx.dv)
    begin
      addr_hit = (line_rx.d == s.waddr[s.mp_pos]);
      bc_hit   = (line_rx.d == `SYNC_BYTE);
      byte_ok  = (s.m_addr && addr_hit) || (s.m_bcast && bc_hit);
      unique case (s.mp_st)
        MP_SYNC:
          if (line_rx.d == `SYNC_BYTE)
          begin
            n.sync_cnt = s.sync_cnt + 3'd1;
            if (s.sync_cnt == `SYNC_LEN - 3'd1)
            begin
              n.mp_st   = MP_ADDR;
              n.mp_pos  = '0;
              n.mp_copy = '0;
              n.m_addr  = 1'b1;
              n.m_bcast = 1'b1;
            end
          end
          else
            n.sync_cnt = '0;
        MP_ADDR:
          if (!byte_ok)
          begin
            // restart; a ff byte may open a new header
            n.mp_st    = MP_SYNC;
            n.sync_cnt = bc_hit ? 3'd1 : 3'd0;
          end
          else
          begin
            n.m_addr  = s.m_addr && addr_hit;
            n.m_bcast = s.m_bcast && bc_hit;
            n.mp_pos  = s.mp_pos + 3'd1;
            if (s.mp_pos == `ADDR_LEN - 3'd1)
            begin
              n.mp_pos  = '0;
              n.mp_copy = s.mp_copy + 4'd1;
              // last of the address copies just completed
              if ({1'b0, s.mp_copy} == `ADDR_COPIES - 5'd1)
              begin
                n.mp_st    = pass_set ? MP_PASS : MP_SYNC;
                n.sync_cnt = '0;
                n.detect   = !pass_set;
              end
            end
          end
        MP_PASS:
          if (line_rx.d != s.wpass[s.mp_pos])
          begin
            n.mp_st    = MP_SYNC;
            n.sync_cnt = bc_hit ? 3'd1 : 3'd0;
          end
          else if (s.mp_pos == `PASS_LEN - 3'd1)
          begin
            n.mp_st    = MP_SYNC;
            n.sync_cnt = '0;
            n.detect   = 1'b1;
          end
          else
            n.mp_pos = s.mp_pos + 3'd1;
        default:
          n.mp_st = MP_SYNC;
      endcase
    end

    // sticky wake event; set wins over a same cycle clear
    if (n.detect)
      n.wake_evt = 1'b1;
  end

  // --------------------------------------------------------------
  // state register
  // --------------------------------------------------------------

  // all flops reset to constants
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s        <= '0;
      s.amp_en <= `RST_PHY_CONTROL_ONE;
      s.adv    <= `RST_EEE_ADVERT;
      s.tx_st  <= TX_ACTIVE;
      s.mp_st  <= MP_SYNC;
    end
    else
      s <= n;
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------

  assign prdata  = s.rdata;
  // error flag belongs to reads only; a write never reports it
  assign pslverr = s.slverr && psel && penable && !pwrite;
  assign pready  = 1'b1;                     // zero wait slave
  assign mac_rx  = s.rx_out;
  // reduced amplitude gated by enable, speed and fallback
  assign amp_reduced = s.amp_en && link_up &&
                       link_speed == SPD_10 && !s.amp_fallback;
  // sleep signalled in the sleep and quiet states, quiet or not
  assign tx_lpi_signal = (s.tx_st == TX_SLEEP) || (s.tx_st == TX_QUIET);
  assign tx_quiet      = (s.tx_st == TX_QUIET);
  assign rx_path_off   = s.rx_lpi;
  assign eee_np_ability = s.adv;
  assign eee_np_valid   = (s.adv != '0);
  assign eee_capable    = s.eee_cap;
  assign mgmt_interrupt_out = s.wake_evt && s.irq_mask;

  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------

  property p_amp_gate;
    @(posedge pclk) disable iff (!presetn)
    amp_reduced |-> s.amp_en && link_speed == SPD_10;
  endproperty
  a_amp_gate: assert property (p_amp_gate)
    else $error("reduced amplitude without enable");

  property p_fallback;
    @(posedge pclk) disable iff (!presetn)
    (s.amp_en && link_up && marginal_link && link_speed == SPD_10)
      |=> !amp_reduced;
  endproperty
  a_fallback: assert property (p_fallback)
    else $error("no fallback on marginal link");

  property p_tx100;
    @(posedge pclk) disable iff (!presetn)
    (s.tx_st == TX_ACTIVE && s.eee_cap && link_speed == SPD_100 &&
     tx_req) |=> tx_quiet && tx_lpi_signal;
  endproperty
  a_tx100: assert property (p_tx100)
    else $error("100m lpi request not entered");

  property p_rx_code;
    @(posedge pclk) disable iff (!presetn)
    (s.eee_cap && partner_lpi)
      |=> !mac_rx.dv && mac_rx.er && mac_rx.d == 8'h01 && rx_path_off;
  endproperty
  a_rx_code: assert property (p_rx_code)
    else $error("received lpi code missing");

  property p_wake100;
    @(posedge pclk) disable iff (!presetn)
    (tx_quiet && !tx_req && link_speed == SPD_100)
      |-> ##[1:206] s.tx_st == TX_ACTIVE;
  endproperty
  a_wake100: assert property (p_wake100)
    else $error("100m wake too slow");

  property p_gig_quiet;
    @(posedge pclk) disable iff (!presetn)
    (s.tx_st == TX_SLEEP && !partner_lpi) |=> !tx_quiet;
  endproperty
  a_gig_quiet: assert property (p_gig_quiet)
    else $error("quiet without partner sleep");

  property p_forward;
    @(posedge pclk) disable iff (!presetn)
    (s.tx_st == TX_ACTIVE && s.eee_cap && tx_req &&
     link_speed == SPD_1000) |=> tx_lpi_signal;
  endproperty
  a_forward: assert property (p_forward)
    else $error("lpi not forwarded");

  property p_wake1000;
    @(posedge pclk) disable iff (!presetn)
    (tx_lpi_signal && !tx_req && link_speed == SPD_1000)
      |-> ##[1:301] s.tx_st == TX_ACTIVE;
  endproperty
  a_wake1000: assert property (p_wake1000)
    else $error("gigabit wake too slow");

  property p_no_adv;
    @(posedge pclk) disable iff (!presetn)
    (s.adv == '0) |-> !eee_np_valid ##1 !eee_capable;
  endproperty
  a_no_adv: assert property (p_no_adv)
    else $error("eee active with zero advertisement");

  property p_lp_store;
    @(posedge pclk) disable iff (!presetn)
    $rose(aneg_done) |=> s.lp_adv == $past(partner_ability);
  endproperty
  a_lp_store: assert property (p_lp_store)
    else $error("partner abilities not stored");

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
    (n.detect && s.irq_mask && !wr_acc) |=> mgmt_interrupt_out;
  endproperty
  a_irq: assert property (p_irq)
    else $error("wake interrupt not raised");

  c_gig_quiet: cover property (@(posedge pclk) disable iff (!presetn)
    s.tx_st == TX_SLEEP ##1 tx_quiet);
  c_detect: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(mgmt_interrupt_out));
  c_rx_lpi: cover property (@(posedge pclk) disable iff (!presetn)
    $fell(rx_path_off));

endmodule

`default_nettype wire

// ==== verification/link_far.sv ====
// far side model: mac lpi agent and decoded line receive stream
`timescale 1ns/10ps
`default_nettype none
`include "phy_eee_regs.svh"
module link_far
  import phy_eee_pkg::*;
(
  input  wire logic pclk,
  output mii_tx_s   mac_tx,
  output mii_rx_s   line_rx,
  output logic      line_rx_frame,
  output logic      partner_lpi
);
  // quiet start; idle data is the inverse of the lpi code
  initial
  begin
    mac_tx = '{1'b0, 1'b0, 8'hFE};
    line_rx = '0;
    line_rx_frame = 1'b0;
    partner_lpi = 1'b0;
  end

  // same code byte at both speeds, low nibble is what 100m reads
  task automatic lpi_req(input logic on);
    mac_tx.er <= on;
    mac_tx.d <= on ? `LPI_CODE : 8'hFE;
  endtask

  // line sensed sleep from the far end
  task automatic sense(input logic on);
    partner_lpi <= on;
  endtask

  // steady receive byte outside frames, for passthrough checks
  task automatic hold(input logic [7:0] b);
    line_rx <= '{1'b1, 1'b0, b};
  endtask

  // one valid byte inside a frame
  task automatic put(input logic [7:0] b);
    @(posedge pclk);
    line_rx <= '{1'b1, 1'b0, b};
    line_rx_frame <= 1'b1;
  endtask

  // stray bytes, header, address copies, optional password
  task automatic magic(input logic [47:0] ad, input logic [47:0] pw,
                       input int copies, input logic pw_on);
    put(8'h00);
    put(8'hFF);
    put(8'h00);
    repeat (6) put(`SYNC_BYTE);
    repeat (copies) for (int i = 0; i < 6; i++) put(ad[47-8*i -: 8]);
    if (pw_on) for (int i = 0; i < 6; i++) put(pw[47-8*i -: 8]);
    put(8'h00);
    @(posedge pclk);
    // released data flips so a stale byte is never read as valid
    line_rx <= '{1'b0, 1'b0, ~line_rx.d};
    line_rx_frame <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== verification/phy_eee_lpi_and_wake_on_lan_tb.sv ====
// self-checking bench of the eee lpi and magic packet wake block
`timescale 1ns/10ps
`default_nettype none
`include "phy_eee_regs.svh"
module phy_eee_lpi_and_wake_on_lan_tb
  import phy_eee_pkg::*;
;
  // ------------------------------
  // stimulus and observed signals
  // ------------------------------
  logic        pclk, presetn, psel, penable, pwrite, ev;
  logic        marginal_link, link_up, aneg_done, pready, pslverr;
  logic        line_rx_frame, partner_lpi, amp_reduced, tx_lpi_signal;
  logic        tx_quiet, rx_path_off, eee_np_valid, eee_capable;
  logic        mgmt_interrupt_out;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [2:0]  partner_ability, eee_np_ability;
  logic [47:0] ad;
  speed_e      link_speed;
  mii_tx_s     mac_tx;
  mii_rx_s     mac_rx, line_rx;
  int          mismatches, total_checks;

  phy_eee_lpi_wol phy_eee_lpi_wol_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mac_tx(mac_tx), .mac_rx(mac_rx),
    .line_rx(line_rx), .line_rx_frame(line_rx_frame),
    .partner_lpi(partner_lpi), .marginal_link(marginal_link),
    .link_up(link_up), .link_speed(link_speed), .aneg_done(aneg_done),
    .partner_ability(partner_ability), .amp_reduced(amp_reduced),
    .tx_lpi_signal(tx_lpi_signal), .tx_quiet(tx_quiet),
    .rx_path_off(rx_path_off), .eee_np_ability(eee_np_ability),
    .eee_np_valid(eee_np_valid), .eee_capable(eee_capable),
    .mgmt_interrupt_out(mgmt_interrupt_out)
  );
  link_far link_far_inst (
    .pclk(pclk), .mac_tx(mac_tx), .line_rx(line_rx),
    .line_rx_frame(line_rx_frame), .partner_lpi(partner_lpi)
  );

  // 10 mhz clock
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // whole run is a few thousand cycles; this cuts a hang short
  initial
  begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    stop_test();
  end

  // ------------------------------
  // shared tasks
  // ------------------------------
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input string n, input logic [7:0] a,
                     input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(n, e, rv);
  endtask

  // six byte registers, first byte at the base
  task automatic prog(input logic [7:0] base, input logic [47:0] v);
    for (int i = 0; i < 6; i++)
      wr(base + 8'(4 * i), 32'(v[47-8*i -: 8]));
  endtask

  // fresh negotiation; partner offers 100m and 1000m eee by default
  task automatic negotiate(input speed_e s, input logic [2:0] pa = 3'h6);
    link_speed <= s;
    partner_ability <= pa;
    aneg_done <= 1'b0;
    cyc(1);
    aneg_done <= 1'b1;
    cyc(3);
  endtask

  // detection lands one cycle on; four covers the frame tail
  task automatic irq_is(input logic e);
    cyc(4);
    chk("interrupt", e, mgmt_interrupt_out);
  endtask

  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic t_reset();
    rdc("ctrl", `OFS_PHY_CONTROL_ONE, 32'h0000_0000);
    rdc("advert", `OFS_EEE_ADVERT, 32'h0000_0000);
    rdc("status", `OFS_MEDIA_IF_STATUS, 32'h0000_0000);
    rdc("hole", 8'h1C, 32'h0000_0000);
    chk("slverr", 1'b1, ev);
    wr(`OFS_EEE_PARTNER, 32'h0000_0007);
    rdc("partner ro", `OFS_EEE_PARTNER, 32'h0000_0000);
  endtask

  task automatic t_amp();
    link_speed <= SPD_10;
    link_up <= 1'b1;
    cyc(2);
    chk("amp off", 1'b0, amp_reduced);
    wr(`OFS_PHY_CONTROL_ONE, 32'h0000_0001);
    cyc(2);
    chk("amp on", 1'b1, amp_reduced);
    marginal_link <= 1'b1;
    cyc(3);
    chk("amp back", 1'b0, amp_reduced);
    rdc("fallback", `OFS_MEDIA_IF_STATUS, 32'h0000_0002);
    marginal_link <= 1'b0;
    wr(`OFS_PHY_CONTROL_ONE, 32'h0000_0000);
  endtask

  task automatic t_advert();
    negotiate(SPD_1000);
    chk("np off", 1'b0, eee_np_valid);
    chk("cap off", 1'b0, eee_capable);
    link_far_inst.lpi_req(1'b1);
    cyc(3);
    chk("refused", 1'b0, tx_lpi_signal);
    link_far_inst.lpi_req(1'b0);
    wr(`OFS_EEE_ADVERT, 32'h0000_0006);
    negotiate(SPD_10);
    chk("cap at 10", 1'b0, eee_capable);
    negotiate(SPD_1000, 3'h2);
    chk("cap no partner", 1'b0, eee_capable);
    rdc("partner 100", `OFS_EEE_PARTNER, 32'h0000_0002);
    negotiate(SPD_1000);
    chk("np ability", 3'h6, eee_np_ability);
    chk("np valid", 1'b1, eee_np_valid);
    rdc("partner", `OFS_EEE_PARTNER, 32'h0000_0006);
    chk("cap", 1'b1, eee_capable);
    link_up <= 1'b0;
    cyc(2);
    chk("cap link down", 1'b0, eee_capable);
    link_up <= 1'b1;
    rdc("eee bit", `OFS_MEDIA_IF_STATUS, 32'h0000_0001);
  endtask

  task automatic t_tx(input speed_e s);
    int w;
    w = (s == SPD_100) ? `WAKE_100_CYC : `WAKE_1000_CYC;
    negotiate(s);
    link_far_inst.lpi_req(1'b1);
    cyc(3);
    chk("lpi signal", 1'b1, tx_lpi_signal);
    chk("quiet", s == SPD_100, tx_quiet);
    chk("rx apart", 1'b0, rx_path_off);
    link_far_inst.sense(1'b1);
    cyc(3);
    chk("quiet both", 1'b1, tx_quiet);
    link_far_inst.lpi_req(1'b0);
    link_far_inst.sense(1'b0);
    cyc(3);
    chk("tx wake", 1'b0, tx_lpi_signal);
    rdc("tx waking", `OFS_MEDIA_IF_STATUS, 32'h0000_0005);
    cyc(w);
    rdc("tx active", `OFS_MEDIA_IF_STATUS, 32'h0000_0001);
  endtask

  task automatic t_rx(input speed_e s);
    int w;
    int n;
    w = (s == SPD_100) ? `WAKE_100_CYC : `WAKE_1000_CYC;
    negotiate(s);
    link_far_inst.hold(8'h5A);
    link_far_inst.sense(1'b1);
    cyc(3);
    chk("rx lpi code", 32'h0000_0101, 32'(mac_rx));
    chk("rx path off", 1'b1, rx_path_off);
    rdc("rx lpi bit", `OFS_MEDIA_IF_STATUS, 32'h0000_0009);
    link_far_inst.sense(1'b0);
    n = 0;
    // mac side stays blank for the whole wake time
    while (mac_rx.dv !== 1'b1 && n < 400)
    begin
      cyc(1);
      n++;
    end
    chk("rx wake span", 1'b1, n >= w && n <= w + 4);
    chk("rx data", 32'h0000_025A, 32'(mac_rx));
  endtask

  task automatic t_wake();
    ad = 48'hA1B2_C3D4_E5F6;
    prog(`OFS_WAKE_ADDR0, ad);
    prog(`OFS_WAKE_PASS0, 48'h0000_0000_0000);
    wr(`OFS_IRQ_MASK, 32'h0000_0001);
    wr(`OFS_WAKE_CTRL, 32'h0000_0001);
    for (int k = 0; k < 3; k++)
    begin
      link_speed <= speed_e'(2'(k));
      link_far_inst.magic(ad, 48'h0000_0000_0000, 16, 1'b0);
      irq_is(1'b1);
      wr(`OFS_WAKE_STATUS, 32'h0000_0001);
      irq_is(1'b0);
    end
    link_far_inst.magic(ad, 48'h0000_0000_0000, 15, 1'b0);
    irq_is(1'b0);
    prog(`OFS_WAKE_PASS0, 48'h0011_2233_4455);
    link_far_inst.magic(ad, 48'h0011_2233_4456, 16, 1'b1);
    irq_is(1'b0);
    link_far_inst.magic(ad, 48'h0011_2233_4455, 16, 1'b1);
    irq_is(1'b1);
    wr(`OFS_WAKE_STATUS, 32'h0000_0001);
    irq_is(1'b0);
    link_far_inst.magic(48'hFFFF_FFFF_FFFF, 48'h0011_2233_4455, 16, 1'b1);
    irq_is(1'b1);
    wr(`OFS_IRQ_MASK, 32'h0000_0000);
    irq_is(1'b0);
    rdc("event", `OFS_WAKE_STATUS, 32'h0000_0001);
  endtask

  // ------------------------------
  // verdict and main sequence
  // ------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    marginal_link = 1'b0;
    link_up = 1'b0;
    aneg_done = 1'b0;
    partner_ability = 3'h0;
    link_speed = SPD_10;
    presetn = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_amp();
    t_advert();
    t_tx(SPD_100);
    t_tx(SPD_1000);
    t_rx(SPD_100);
    t_rx(SPD_1000);
    t_wake();
    stop_test();
  end
endmodule
`default_nettype wire
